// >>> baud_pkg.sv
// Shared constants and types of the serial baud rate generator.
package baud_pkg;
    localparam int unsigned ADDR_W = 8;
    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] OFS_TXCS = 8'h00;
    localparam logic [7:0] OFS_RXCS = 8'h04;
    localparam logic [7:0] OFS_BAUD = 8'h08;
    localparam logic [7:0] OFS_DIVH = 8'h0c;
    localparam logic [7:0] OFS_DIVL = 8'h10;
    localparam logic [7:0] OFS_ISTS = 8'h14;
    localparam logic [7:0] OFS_IMSK = 8'h18;
    // Field positions.
    localparam int unsigned SYNC_BIT  = 4;
    localparam int unsigned HSPD_BIT  = 2;
    localparam int unsigned SERIAL_PORT_ENABLE_BIT  = 7;
    localparam int unsigned ABOV_BIT  = 7;
    localparam int unsigned IDLE_BIT  = 6;
    localparam int unsigned RXPOL_BIT = 5;
    localparam int unsigned TXPOL_BIT = 4;
    localparam int unsigned WIDE_BIT  = 3;
    localparam int unsigned WAKE_BIT  = 1;
    localparam int unsigned ABEN_BIT  = 0;
    // Writable bits and reset values.
    localparam logic [7:0] TXCS_WMASK = 8'hfd;
    localparam logic [7:0] RXCS_WMASK = 8'hf8;
    localparam logic [7:0] BAUD_WMASK = 8'hb9;
    localparam logic [7:0] TXCS_RST   = 8'h02;
    localparam logic [7:0] RXCS_RST   = 8'h00;
    localparam logic [7:0] BAUD_RST   = 8'h00;
    localparam logic [7:0] DIV_RST    = 8'h00;
    // Prescaler terminal counts (multiplier minus one) and sync shift and sample phases.
    localparam logic [5:0] PRE_M64 = 6'h3f;
    localparam logic [5:0] PRE_M16 = 6'h0f;
    localparam logic [5:0] PRE_M4  = 6'h03;
    localparam logic [5:0] PRE_SHIFT  = 6'h02;
    localparam logic [5:0] PRE_SAMPLE = 6'h00;
    // Interrupt status bits.
    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_WAKE   = 0;
    localparam int unsigned IRQ_ABOV   = 1;
    localparam int unsigned IRQ_ABDONE = 2;

    typedef enum logic [1:0] {
        WAKE_OFF  = 2'b00,
        WAKE_FALL = 2'b01,
        WAKE_RISE = 2'b11
    } wake_t;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADDR_W-1:0] adr;
        logic [3:0]        sel;
        logic [31:0]       dat;
    } wb_req_t;
endpackage

// >>> serial_baud_rate_generator.sv
// Baud rate generator, baud control register and Wishbone register file.
`timescale 1ns/1ps
// Behaviour
// RULE_01: Async mode: overflow flag sets when the auto-baud timer overflows.
// RULE_02: Async mode: idle flag reads one when receiver idle, resets to one.
// RULE_03: Receive polarity one inverts the incoming data line.
// RULE_04: Async mode: transmit polarity one makes transmit idle low.
// RULE_05: Sync mode: clock polarity picks which edge changes and which samples.
// RULE_06: Width bit selects sixteen-bit divisor, else low byte only.
// RULE_07: Bit two of baud control always reads zero.
// RULE_08: Wake enable waits for falling edge, flags it, clears on rise.
// RULE_09: Auto-baud enable starts detection and clears itself when done.
// RULE_10: Serves both modes; eight-bit divider after reset.
// RULE_11: Divisor sets period of a free running reloading baud timer.
// RULE_12: Sync mode ignores the high speed bit.
// RULE_13: Any divisor byte write clears the baud timer at once.
// RULE_14: Rates: async 8-bit low 64(n+1), 16-bit low 16(n+1), sync 4(n+1).
// RULE_15: Software checks idle flag before changing the system clock.
// RULE_16: Mode bit one selects sync operation, zero async.
// RULE_17: Async high speed bit selects the high speed multiplier.
// RULE_18: Clearing port enable holds the generator in reset.
// RULE_19: Async high speed: 8-bit 16(n+1), 16-bit 4(n+1).
module serial_baud_rate_generator (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire baud_pkg::wb_req_t wb_req_i,
    output logic                   wb_ack_o,
    output logic [31:0]            wb_dat_o,
    input  wire logic              rx_pin_i,
    input  wire logic              rx_busy_i,
    input  wire logic              autobaud_done_i,
    input  wire logic              autobaud_overflow_i,
    output logic                   baud_tick_o,
    output logic                   sync_clk_o,
    output logic                   shift_stb_o,
    output logic                   sample_stb_o,
    output logic                   rx_data_o,
    output logic                   tx_idle_level_o,
    output logic                   rx_block_o,
    output logic                   wake_pulse_o,
    output logic                   autobaud_active_o,
    output logic                   irq_o
);
    typedef struct packed {
        logic [7:0]                txcs;
        logic [7:0]                rxcs;
        logic [7:0]                baud;
        logic [7:0]                divh;
        logic [7:0]                divl;
        logic [15:0]               timer;
        logic [5:0]                pre;
        baud_pkg::wake_t           wake;
        logic                      idle;
        logic                      rx_s1;
        logic                      rx_s2;
        logic                      rx_lvl;
        logic [baud_pkg::IRQ_W-1:0] ists;
        logic [baud_pkg::IRQ_W-1:0] imsk;
        logic                      ack;
        logic [31:0]               dat;
        logic                      irq;
        logic                      tick;
        logic                      sclk;
        logic                      shift;
        logic                      sample;
        logic                      tx_idle;
        logic                      wake_pulse;
        logic                      ab_active;
    } state_t;

    localparam state_t RST_STATE = '{
        txcs: baud_pkg::TXCS_RST, rxcs: baud_pkg::RXCS_RST,
        baud: baud_pkg::BAUD_RST, divh: baud_pkg::DIV_RST,
        divl: baud_pkg::DIV_RST, timer: 16'h0000, pre: 6'h00,
        wake: baud_pkg::WAKE_OFF, idle: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1,
        rx_lvl: 1'b1, ists: 3'h0, imsk: 3'h0, ack: 1'b0, dat: 32'h0000_0000,
        irq: 1'b0, tick: 1'b0, sclk: 1'b0, shift: 1'b0, sample: 1'b0,
        tx_idle: 1'b1, wake_pulse: 1'b0, ab_active: 1'b0
    };

    state_t s_r;
    state_t s_nxt;

    logic                       hit;
    logic                       wr;
    logic                       serial_port_enable;
    logic                       sync_mode;
    logic                       rx_norm;
    logic                       rx_fall;
    logic                       rx_rise;
    logic [15:0]                divisor;
    logic [5:0]                 pre_max;
    logic [7:0]                 wdat;
    logic [7:0]                 baud_rd;
    logic [baud_pkg::IRQ_W-1:0] ev;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.shift  = 1'b0;
        s_nxt.sample = 1'b0;
        s_nxt.wake_pulse = 1'b0;
        ev         = '0;
        hit        = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;
        wr         = hit & wb_req_i.we & wb_req_i.sel[0];
        wdat       = wb_req_i.dat[7:0];
        serial_port_enable       = s_r.rxcs[baud_pkg::SERIAL_PORT_ENABLE_BIT];
        sync_mode  = s_r.txcs[baud_pkg::SYNC_BIT]; // RULE_16
        rx_norm    = s_r.rx_s2 ^ s_r.baud[baud_pkg::RXPOL_BIT]; // RULE_03
        rx_fall    = s_r.rx_lvl & ~rx_norm;
        rx_rise    = ~s_r.rx_lvl & rx_norm;
        // RULE_06 RULE_10
        divisor = s_r.baud[baud_pkg::WIDE_BIT] ? {s_r.divh, s_r.divl} : {8'h00, s_r.divl};
        // The high speed bit only matters in async mode.
        if (sync_mode) begin
            pre_max = baud_pkg::PRE_M4; // RULE_12 RULE_14
        end else if (s_r.baud[baud_pkg::WIDE_BIT]) begin
            pre_max = s_r.txcs[baud_pkg::HSPD_BIT] ? baud_pkg::PRE_M4 : baud_pkg::PRE_M16;
        end else begin
            pre_max = s_r.txcs[baud_pkg::HSPD_BIT] ? baud_pkg::PRE_M16 : baud_pkg::PRE_M64;
        end
        baud_rd = {s_r.baud[baud_pkg::ABOV_BIT], s_r.idle, s_r.baud[5:3], 1'b0, // RULE_07
                   s_r.wake != baud_pkg::WAKE_OFF, s_r.baud[baud_pkg::ABEN_BIT]};

        // Free running timer; a terminal count at or past the divisor reloads it, so a
        // smaller divisor never stalls the timer.
        if (s_r.timer >= divisor) begin // RULE_11
            s_nxt.timer = 16'h0000;
            if (s_r.pre >= pre_max) begin // RULE_14 RULE_17 RULE_19
                s_nxt.pre  = 6'h00;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.pre = s_r.pre + 6'h01;
            end
            s_nxt.shift  = sync_mode & (s_nxt.pre == baud_pkg::PRE_SHIFT); // RULE_05
            s_nxt.sample = sync_mode & (s_nxt.pre == baud_pkg::PRE_SAMPLE); // RULE_05
        end else begin
            s_nxt.timer = s_r.timer + 16'h0001;
        end

        s_nxt.rx_s1  = rx_pin_i;
        s_nxt.rx_s2  = s_r.rx_s1;
        s_nxt.rx_lvl = rx_norm;

        unique case (s_r.wake)
            baud_pkg::WAKE_OFF: begin
            end
            baud_pkg::WAKE_FALL: begin
                if (rx_fall) begin // RULE_08
                    s_nxt.wake       = baud_pkg::WAKE_RISE;
                    s_nxt.wake_pulse = 1'b1;
                    ev[baud_pkg::IRQ_WAKE] = 1'b1;
                end
            end
            baud_pkg::WAKE_RISE: begin
                if (rx_rise) begin // RULE_08
                    s_nxt.wake = baud_pkg::WAKE_OFF;
                end
            end
            default: begin
                s_nxt.wake = baud_pkg::WAKE_OFF;
            end
        endcase

        s_nxt.ack = hit;
        s_nxt.dat = 32'h0000_0000;
        if (hit & ~wb_req_i.we) begin
            case (wb_req_i.adr)
                baud_pkg::OFS_TXCS: s_nxt.dat[7:0] = s_r.txcs;
                baud_pkg::OFS_RXCS: s_nxt.dat[7:0] = s_r.rxcs;
                baud_pkg::OFS_BAUD: s_nxt.dat[7:0] = baud_rd;
                baud_pkg::OFS_DIVH: s_nxt.dat[7:0] = s_r.divh;
                baud_pkg::OFS_DIVL: s_nxt.dat[7:0] = s_r.divl;
                baud_pkg::OFS_ISTS: s_nxt.dat[baud_pkg::IRQ_W-1:0] = s_r.ists;
                baud_pkg::OFS_IMSK: s_nxt.dat[baud_pkg::IRQ_W-1:0] = s_r.imsk;
                default: s_nxt.dat = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (wb_req_i.adr)
                baud_pkg::OFS_TXCS: begin
                    s_nxt.txcs = (wdat & baud_pkg::TXCS_WMASK) | (s_r.txcs & ~baud_pkg::TXCS_WMASK);
                end
                baud_pkg::OFS_RXCS: begin
                    s_nxt.rxcs = (wdat & baud_pkg::RXCS_WMASK) | (s_r.rxcs & ~baud_pkg::RXCS_WMASK);
                end
                baud_pkg::OFS_BAUD: begin
                    s_nxt.baud = (wdat & baud_pkg::BAUD_WMASK) | (s_r.baud & ~baud_pkg::BAUD_WMASK);
                    if (!wdat[baud_pkg::WAKE_BIT]) begin
                        s_nxt.wake = baud_pkg::WAKE_OFF;
                    end else if (s_r.wake == baud_pkg::WAKE_OFF) begin
                        s_nxt.wake = baud_pkg::WAKE_FALL; // RULE_08
                    end
                end
                baud_pkg::OFS_DIVH: begin
                    s_nxt.divh  = wdat;
                    s_nxt.timer = 16'h0000; // RULE_13
                    s_nxt.pre   = 6'h00;
                end
                baud_pkg::OFS_DIVL: begin
                    s_nxt.divl  = wdat;
                    s_nxt.timer = 16'h0000; // RULE_13
                    s_nxt.pre   = 6'h00;
                end
                baud_pkg::OFS_ISTS: s_nxt.ists = s_r.ists & ~wdat[baud_pkg::IRQ_W-1:0];
                baud_pkg::OFS_IMSK: s_nxt.imsk = wdat[baud_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        // Hardware updates come after software so that hardware wins over a same-cycle write.
        if (s_r.baud[baud_pkg::ABEN_BIT] & autobaud_done_i) begin
            s_nxt.baud[baud_pkg::ABEN_BIT] = 1'b0; // RULE_09
            ev[baud_pkg::IRQ_ABDONE] = 1'b1;
        end
        if (~sync_mode & autobaud_overflow_i) begin
            s_nxt.baud[baud_pkg::ABOV_BIT] = 1'b1; // RULE_01
            ev[baud_pkg::IRQ_ABOV] = 1'b1;
        end
        s_nxt.idle = sync_mode | ~rx_busy_i; // RULE_02

        // Wake and auto-baud are meaningless in sync mode.
        if (sync_mode) begin
            s_nxt.wake = baud_pkg::WAKE_OFF;
        end
        if (!serial_port_enable) begin // RULE_18
            s_nxt.timer  = 16'h0000;
            s_nxt.pre    = 6'h00;
            s_nxt.tick   = 1'b0;
            s_nxt.shift  = 1'b0;
            s_nxt.sample = 1'b0;
            s_nxt.wake   = baud_pkg::WAKE_OFF;
            s_nxt.wake_pulse = 1'b0;
            s_nxt.idle   = 1'b1;
            s_nxt.baud[baud_pkg::ABEN_BIT] = 1'b0;
            s_nxt.baud[baud_pkg::ABOV_BIT] = 1'b0;
            ev = '0;
        end
        s_nxt.ists = s_nxt.ists | ev;
        s_nxt.irq  = |(s_nxt.ists & s_nxt.imsk);
        // A divisor write restarts the prescaler, so the shift strobe must follow the final step.
        s_nxt.shift = s_nxt.shift & (s_nxt.pre == baud_pkg::PRE_SHIFT); // RULE_05
        s_nxt.sclk = serial_port_enable & sync_mode & (s_nxt.pre[1] ^ s_nxt.baud[baud_pkg::TXPOL_BIT]);
        s_nxt.tx_idle = ~s_r.baud[baud_pkg::TXPOL_BIT]; // RULE_04
        s_nxt.ab_active = s_nxt.baud[baud_pkg::ABEN_BIT] & ~sync_mode & serial_port_enable;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o          = s_r.ack;
    assign wb_dat_o          = s_r.dat;
    assign baud_tick_o       = s_r.tick;
    assign sync_clk_o        = s_r.sclk;
    assign shift_stb_o       = s_r.shift;
    assign sample_stb_o      = s_r.sample;
    assign rx_data_o         = s_r.rx_lvl;
    assign tx_idle_level_o   = s_r.tx_idle;
    assign rx_block_o        = s_r.wake[0];
    assign wake_pulse_o      = s_r.wake_pulse;
    assign autobaud_active_o = s_r.ab_active;
    assign irq_o             = s_r.irq;

    // Checking helpers: cycles between ticks, armed only while nothing is rewritten.
    logic [23:0] gap_r;
    logic        armed_r;
    logic [23:0] want;
    assign want = 24'((32'(pre_max) + 32'h1) * (32'(divisor) + 32'h1));

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || wr || !serial_port_enable) begin
            gap_r   <= 24'h000001;
            armed_r <= 1'b0;
        end else begin
            gap_r   <= s_r.tick ? 24'h000001 : gap_r + 24'h000001;
            armed_r <= armed_r | s_r.tick;
        end
    end

    property p_ovf_set;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (serial_port_enable && !sync_mode && autobaud_overflow_i) |=> s_r.baud[baud_pkg::ABOV_BIT];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set"); // RULE_01

    property p_idle;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (serial_port_enable && !sync_mode) |=> (s_r.idle == !$past(rx_busy_i));
    endproperty
    a_idle: assert property (p_idle) else $error("idle flag wrong"); // RULE_02

    property p_rx_pol;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ($past(rst_n_i, 3) && $past(rst_n_i, 2) && $past(rst_n_i))
            |-> rx_data_o == ($past(rx_pin_i, 3) ^ $past(s_r.baud[baud_pkg::RXPOL_BIT]));
    endproperty
    a_rx_pol: assert property (p_rx_pol) else $error("receive polarity wrong"); // RULE_03

    property p_tx_idle;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> tx_idle_level_o == !$past(s_r.baud[baud_pkg::TXPOL_BIT]);
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("transmit idle level wrong"); // RULE_04

    property p_edges;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (shift_stb_o |-> sync_clk_o != s_r.baud[baud_pkg::TXPOL_BIT])
        and (sample_stb_o |-> sync_clk_o == s_r.baud[baud_pkg::TXPOL_BIT]);
    endproperty
    a_edges: assert property (p_edges) else $error("sync clock edge wrong"); // RULE_05

    property p_period;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (baud_tick_o && armed_r) |-> gap_r == want;
    endproperty
    a_period: assert property (p_period) else $error("baud period wrong"); // RULE_14

    property p_bit2;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (hit && !wb_req_i.we && wb_req_i.adr == baud_pkg::OFS_BAUD) |=> !wb_dat_o[2];
    endproperty
    a_bit2: assert property (p_bit2) else $error("bit two reads one"); // RULE_07

    property p_wake;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (s_r.wake == baud_pkg::WAKE_FALL && rx_fall && serial_port_enable && !sync_mode)
            |=> wake_pulse_o && s_r.ists[baud_pkg::IRQ_WAKE] && rx_block_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake event missed"); // RULE_08

    property p_abd_done;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (s_r.baud[baud_pkg::ABEN_BIT] && autobaud_done_i) |=> !autobaud_active_o;
    endproperty
    a_abd_done: assert property (p_abd_done) else $error("auto-baud not cleared"); // RULE_09

    property p_div_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr && (wb_req_i.adr == baud_pkg::OFS_DIVH || wb_req_i.adr == baud_pkg::OFS_DIVL))
            |=> s_r.timer == 16'h0000 && s_r.pre == 6'h00;
    endproperty
    a_div_clear: assert property (p_div_clear) else $error("timer not cleared"); // RULE_13

    property p_disabled;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !serial_port_enable |=> !baud_tick_o && s_r.timer == 16'h0000 && !rx_block_o;
    endproperty
    a_disabled: assert property (p_disabled) else $error("generator runs while off"); // RULE_18

    c_tick_wide: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        baud_tick_o && armed_r && s_r.baud[baud_pkg::WIDE_BIT]);
    c_wake: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) wake_pulse_o);
    c_ovf: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_r.ists[baud_pkg::IRQ_ABOV] && irq_o);
    c_sample: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) sample_stb_o);
endmodule

// >>> remote_serial_model.sv
// Remote serial device that drives the receive line and the receiver busy level.
`timescale 1ns/1ps
module remote_serial_model (
    input  wire logic core_clk_i,
    output logic      rx_pin_o,
    output logic      rx_busy_o
);
    initial begin
        rx_pin_o  = 1'b1;
        rx_busy_o = 1'b0;
    end

    // The line idles high; busy follows the start edge a cycle late, as a real receiver would.
    task automatic frame(input int low_cycles);
        @(posedge core_clk_i);
        rx_pin_o <= 1'b0;
        @(posedge core_clk_i);
        rx_busy_o <= 1'b1;
        repeat (low_cycles) @(posedge core_clk_i);
        rx_pin_o <= 1'b1;
        @(posedge core_clk_i);
        rx_busy_o <= 1'b0;
    endtask
endmodule

// >>> serial_baud_rate_generator_tb.sv
// Self-checking testbench of the baud rate generator over its Wishbone registers.
`timescale 1ns/1ps
module serial_baud_rate_generator_tb;
    logic              core_clk = 1'b0;
    logic              rst_n    = 1'b0;
    baud_pkg::wb_req_t wb_req   = '0;
    logic              wb_ack;
    logic [31:0]       wb_dat;
    logic              rx_pin;
    logic              rx_busy;
    logic              ab_done  = 1'b0;
    logic              ab_ovf   = 1'b0;
    logic              baud_tick;
    logic              sync_clk;
    logic              shift_stb;
    logic              sample_stb;
    logic              rx_data;
    logic              tx_idle;
    logic              rx_block;
    logic              wake_pulse;
    logic              ab_active;
    logic              irq;
    logic              a0, b0, a1, b1;
    int                bad_count    = 0;
    int                total_checks = 0;
    int                cycles       = 0;
    int                wake_cnt     = 0;
    int                tick_cnt     = 0;
    int                wait_n;
    int                t;
    logic [7:0]        c_tx [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
    logic [7:0]        c_bd [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
    logic [7:0]        c_dh [6] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    logic [7:0]        c_dl [6] = '{8'h02, 8'h02, 8'h00, 8'h03, 8'h03, 8'h05};
    int                c_per [6] = '{192, 48, 4112, 1040, 16, 24};

    always #5 core_clk = ~core_clk;

    serial_baud_rate_generator serial_baud_rate_generator_i (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .wb_req_i(wb_req), .wb_ack_o(wb_ack),
        .wb_dat_o(wb_dat), .rx_pin_i(rx_pin), .rx_busy_i(rx_busy),
        .autobaud_done_i(ab_done), .autobaud_overflow_i(ab_ovf), .baud_tick_o(baud_tick),
        .sync_clk_o(sync_clk), .shift_stb_o(shift_stb), .sample_stb_o(sample_stb),
        .rx_data_o(rx_data), .tx_idle_level_o(tx_idle), .rx_block_o(rx_block),
        .wake_pulse_o(wake_pulse), .autobaud_active_o(ab_active), .irq_o(irq)
    );

    remote_serial_model remote_serial_model_i (
        .core_clk_i(core_clk), .rx_pin_o(rx_pin), .rx_busy_o(rx_busy)
    );

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (wake_pulse === 1'b1) wake_cnt++;
        if (baud_tick === 1'b1) tick_cnt++;
        if (cycles == 40000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The request is held until the edge that samples ack; read data is taken from that cycle.
    task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
        @(posedge core_clk);
        check("ack drop", 32'h0, {31'h0, wb_ack});
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
        do begin
            @(posedge core_clk);
        end while (wb_ack !== 1'b1);
        rd = wb_dat;
        wb_req <= '0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] r;
        access(1'b1, adr, {24'h0, d}, r);
    endtask

    task automatic rd(input string what, input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] r;
        access(1'b0, adr, 32'h0, r);
        check(what, {24'h0, exp}, r);
    endtask

    task automatic wait_for(input int which);
        int   n;
        logic s;
        n = 0;
        s = 1'b0;
        while (s !== 1'b1 && n < 20000) begin
            @(negedge core_clk);
            n++;
            s = (which == 0) ? baud_tick : (which == 1) ? shift_stb : sample_stb;
        end
        wait_n = n;
    endtask

    task automatic pulse(input logic ovf);
        @(posedge core_clk);
        if (ovf) ab_ovf <= 1'b1;
        else ab_done <= 1'b1;
        @(posedge core_clk);
        ab_ovf  <= 1'b0;
        ab_done <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd("txcs", baud_pkg::OFS_TXCS, 8'h02);
        rd("rxcs", baud_pkg::OFS_RXCS, 8'h00);
        rd("baud", baud_pkg::OFS_BAUD, 8'h40);
        rd("divh", baud_pkg::OFS_DIVH, 8'h00);
        rd("divl", baud_pkg::OFS_DIVL, 8'h00);
        rd("ists", baud_pkg::OFS_ISTS, 8'h00);
        rd("imsk", baud_pkg::OFS_IMSK, 8'h00);
        rd("unmapped", 8'h1c, 8'h00);
        check("tx idle", 32'h1, {31'h0, tx_idle});
        wr(baud_pkg::OFS_BAUD, 8'h3c);
        rd("baud pol", baud_pkg::OFS_BAUD, 8'h78);
        check("tx idle inv", 32'h0, {31'h0, tx_idle});
        check("rx inv", 32'h0, {31'h0, rx_data});
        wr(baud_pkg::OFS_BAUD, 8'h00);
        @(negedge core_clk);
        check("rx plain", 32'h1, {31'h0, rx_data});
        wr(baud_pkg::OFS_RXCS, 8'h80);
        for (int i = 0; i < 6; i++) begin
            wr(baud_pkg::OFS_TXCS, c_tx[i]);
            wr(baud_pkg::OFS_BAUD, c_bd[i]);
            wr(baud_pkg::OFS_DIVH, c_dh[i]);
            wr(baud_pkg::OFS_DIVL, c_dl[i]);
            wait_for(0);
            wait_for(0);
            check("period", c_per[i], wait_n);
        end
        // A long old count must not delay the new rate.
        wr(baud_pkg::OFS_TXCS, 8'h00);
        wr(baud_pkg::OFS_DIVH, 8'h01);
        repeat (100) @(posedge core_clk);
        wr(baud_pkg::OFS_DIVH, 8'h00);
        wait_for(0);
        check("restart", 32'h60, wait_n);
        wr(baud_pkg::OFS_TXCS, 8'h10);
        wr(baud_pkg::OFS_DIVL, 8'h00);
        wait_for(1);
        a0 = sync_clk;
        wait_for(2);
        b0 = sync_clk;
        check("sync edges", 32'h2, {30'h0, a0, b0});
        wr(baud_pkg::OFS_BAUD, 8'h10);
        wait_for(1);
        a1 = sync_clk;
        wait_for(2);
        b1 = sync_clk;
        check("sync pol", 32'h0, {31'h0, a1});
        check("sync edges inv", 32'h1, {31'h0, b1});
        wr(baud_pkg::OFS_TXCS, 8'h00);
        wr(baud_pkg::OFS_BAUD, 8'h00);
        wr(baud_pkg::OFS_IMSK, 8'h01);
        wr(baud_pkg::OFS_BAUD, 8'h02);
        rd("wake set", baud_pkg::OFS_BAUD, 8'h42);
        check("rx block", 32'h1, {31'h0, rx_block});
        fork
            remote_serial_model_i.frame(60);
            begin
                repeat (10) @(posedge core_clk);
                rd("wake busy", baud_pkg::OFS_BAUD, 8'h02);
                check("irq on", 32'h1, {31'h0, irq});
                wr(baud_pkg::OFS_IMSK, 8'h00);
                @(negedge core_clk);
                check("irq masked", 32'h0, {31'h0, irq});
            end
        join
        repeat (8) @(posedge core_clk);
        check("wake count", 32'h1, wake_cnt);
        rd("wake clear", baud_pkg::OFS_BAUD, 8'h40);
        rd("ists wake", baud_pkg::OFS_ISTS, 8'h01);
        wr(baud_pkg::OFS_ISTS, 8'h01);
        rd("ists w1c", baud_pkg::OFS_ISTS, 8'h00);
        check("irq off", 32'h0, {31'h0, irq});
        wr(baud_pkg::OFS_BAUD, 8'h01);
        repeat (2) @(negedge core_clk);
        check("ab active", 32'h1, {31'h0, ab_active});
        pulse(1'b1);
        rd("ab ovf", baud_pkg::OFS_BAUD, 8'hc1);
        pulse(1'b0);
        rd("ab done", baud_pkg::OFS_BAUD, 8'hc0);
        check("ab idle", 32'h0, {31'h0, ab_active});
        rd("ists ab", baud_pkg::OFS_ISTS, 8'h06);
        wr(baud_pkg::OFS_RXCS, 8'h00);
        @(negedge core_clk);
        t = tick_cnt;
        repeat (300) @(posedge core_clk);
        check("held ticks", t, tick_cnt);
        check("held clk", 32'h0, {31'h0, sync_clk});
        finish_test();
    end
endmodule
